// [plp_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   analog values are signed 32-bit integers
`ifndef PLP_DEFS_SVH
`define PLP_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PLP_CLK_PERIOD_NS 5
`define PLP_MS_NS         1000000
`define PLP_MS_CYCLES     (`PLP_MS_NS / `PLP_CLK_PERIOD_NS)
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PLP_OFF_CTRL  8'h00
`define PLP_OFF_DIN   8'h04
`define PLP_OFF_ANA_A 8'h08
`define PLP_OFF_ANA_B 8'h0c
`define PLP_OFF_ANA_C 8'h10
`define PLP_OFF_T_PUL 8'h14
`define PLP_OFF_T_DLY 8'h18
`define PLP_OFF_T_HI  8'h1c
`define PLP_OFF_T_LO  8'h20
`define PLP_OFF_FLAGS 8'h24
`define PLP_OFF_FAN   8'h28
`define PLP_OFF_COUNT 8'h2c
`define PLP_OFF_SUM   8'h30
`define PLP_OFF_DIFF  8'h34
`define PLP_OFF_PROD  8'h38
`define PLP_OFF_QUOT  8'h3c
`define PLP_OFF_AMUX  8'h40
`define PLP_OFF_D2A   8'h44
`define PLP_OFF_BCD2A 8'h48
`define PLP_OFF_BIN2A 8'h4c
`define PLP_OFF_A2C   8'h50
// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define PLP_C_CYC_LO 0
`define PLP_C_CYC_HI 1
`define PLP_C_RUN    2
`define PLP_C_OPN_LO 4
`define PLP_C_OPN_HI 8
`define PLP_C_FAN_LO 9
`define PLP_C_FAN_HI 13
`define PLP_C_REL_LO 16
`define PLP_C_REL_HI 18
`define PLP_CTRL_RST 32'h0000_0220
// ----------------------------------------
// digital operand fields
// ----------------------------------------
`define PLP_D_SEL   16
`define PLP_D_CLK   17
`define PLP_D_DATA  18
`define PLP_D_SET   19
`define PLP_D_RST   20
`define PLP_D_TIN   21
`define PLP_D_TRAIN 22
// ----------------------------------------
// result flag positions
// ----------------------------------------
`define PLP_F_AND   0
`define PLP_F_OR    1
`define PLP_F_XOR   2
`define PLP_F_NOT   3
`define PLP_F_MUX   4
`define PLP_F_EDGEQ 5
`define PLP_F_SRQ   6
`define PLP_F_CMP   7
`define PLP_F_HYST  8
`define PLP_F_RISE  9
`define PLP_F_VALID 10
`define PLP_F_TMR   11
`define PLP_ANA_INVALID 32'h8000_0000
`define PLP_CNT_MAX     16'hffff
`endif

// [plp_pkg.sv]
// Purpose: shared types of the logic primitive engine
// Assumes: nothing
// Notes:   cycle and relation codes are stored in control fields, timer modes are parameters
package plp_pkg;
	typedef enum logic [1:0] {
		PLP_CYC_2MS  = 2'h0,
		PLP_CYC_10MS = 2'h1,
		PLP_CYC_20MS = 2'h2
	} plp_cycle_e;
	typedef enum logic [2:0] {
		PLP_REL_GT = 3'h0,
		PLP_REL_LT = 3'h1,
		PLP_REL_EQ = 3'h2,
		PLP_REL_NE = 3'h3,
		PLP_REL_GE = 3'h4,
		PLP_REL_LE = 3'h5
	} plp_rel_e;
	typedef enum logic [3:0] {
		PLP_T_PULSE  = 4'h1,
		PLP_T_ONDLY  = 4'h2,
		PLP_T_OFFDLY = 4'h4,
		PLP_T_TRAIN  = 4'h8
	} plp_tmode_e;
endpackage : plp_pkg

// [plp_timer.sv]
// Purpose: one timed primitive, mode fixed by parameter
// Assumes: tick pulses once per run cycle, stepMs is that period
// Notes:   durations are in milliseconds
`timescale 1ns/1ps
module plp_timer import plp_pkg::*; #(
	parameter plp_tmode_e MODE = PLP_T_PULSE
) (
	input  wire logic        clk,
	input  wire logic        rstN,
	input  wire logic        tick,
	input  wire logic [4:0]  stepMs,
	input  wire logic        inBit,
	input  wire logic [31:0] durOn,
	input  wire logic [31:0] durOff,
	output logic             q
);
	logic [32:0] acc;
	logic [32:0] next_acc;
	logic        prev;
	assign next_acc = acc + {28'h0, stepMs};
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			q    <= 1'b0;
			acc  <= 33'h0;
			prev <= 1'b0;
		end else if (tick) begin
			prev <= inBit;
			case (MODE)
				PLP_T_PULSE: begin
					if (inBit && !prev) begin
						acc <= 33'h0;
						q   <= (durOn != 32'h0);
					end else if (q) begin
						acc <= next_acc;
						if (next_acc >= {1'b0, durOn}) q <= 1'b0;
					end
				end
				PLP_T_ONDLY: begin
					if (!inBit) begin
						acc <= 33'h0;
						q   <= 1'b0;
					end else if (!q) begin
						if (acc >= {1'b0, durOn}) q <= 1'b1;
						else acc <= next_acc;
					end
				end
				PLP_T_OFFDLY: begin
					if (inBit) begin
						q   <= 1'b1;
						acc <= 33'h0;
					end else if (q) begin
						acc <= next_acc;
						if (next_acc > {1'b0, durOn}) q <= 1'b0;
					end
				end
				PLP_T_TRAIN: begin
					if (!inBit) begin
						q   <= 1'b0;
						acc <= 33'h0;
					end else if (!prev) begin
						q   <= 1'b1;
						acc <= 33'h0;
					end else if (next_acc >= {1'b0, (q ? durOn : durOff)}) begin
						q   <= !q;
						acc <= 33'h0;
					end else begin
						acc <= next_acc;
					end
				end
				default: q <= 1'b0;
			endcase
		end
	end
endmodule : plp_timer

// [plp_code_conv.sv]
// Purpose: BCD and binary code converters
// Assumes: analog value is signed 32-bit integer
// Notes:   out-of-range values clamp, invalid input gives zero bits
`timescale 1ns/1ps
module plp_code_conv (
	input  wire logic [15:0] bitsIn,
	input  wire logic [31:0] valIn,
	output logic      [31:0] bcdVal,
	output logic      [31:0] binVal,
	output logic      [15:0] bcdBits,
	output logic      [15:0] binBits
);
	`include "plp_defs.svh"
	logic        badDigit;
	logic [31:0] clampBcd;
	always_comb begin
		badDigit = (bitsIn[3:0] > 4'h9) || (bitsIn[7:4] > 4'h9)
			|| (bitsIn[11:8] > 4'h9) || (bitsIn[15:12] > 4'h9);
		bcdVal = badDigit ? `PLP_ANA_INVALID
			: 32'(bitsIn[15:12]) * 32'd1000 + 32'(bitsIn[11:8]) * 32'd100
			+ 32'(bitsIn[7:4]) * 32'd10 + 32'(bitsIn[3:0]);
		binVal = {16'h0, bitsIn};
		if (valIn == `PLP_ANA_INVALID || $signed(valIn) < 0) clampBcd = 32'h0;
		else if ($signed(valIn) > 32'sd9999) clampBcd = 32'd9999;
		else clampBcd = valIn;
		bcdBits = {4'(clampBcd / 32'd1000), 4'((clampBcd / 32'd100) % 32'd10),
			4'((clampBcd / 32'd10) % 32'd10), 4'(clampBcd % 32'd10)};
		if (valIn == `PLP_ANA_INVALID || $signed(valIn) < 0) binBits = 16'h0;
		else if ($signed(valIn) > 32'sd65535) binBits = 16'hffff;
		else binBits = valIn[15:0];
	end
endmodule : plp_code_conv

// [plp_engine.sv]
// Purpose: logic primitive engine, evaluated once per run cycle
// Assumes: APB master, operands written by software
// Notes:   all results registered on the run-cycle tick
//
// Notes on behaviour
// RL1: AND of 2 to 16 digital operands, high only if all high.
// RL2: OR of 2 to 16 digital operands, high if any high.
// RL3: XOR of two operands, high when they differ.
// RL4: inverter drives complement of its one operand.
// RL5: fan-out copies one operand onto 1 to 16 outputs.
// RL6: digital selector routes one of two operands by selector.
// RL7: analog selector passes one of two values by selector.
// RL8: pulse holds output high for set time after rising input.
// RL9: on-delay raises output after input high for delay; drops on low.
// RL10: off-delay holds output high while input high and delay after.
// RL11: edge latch captures data on rising edge of clock operand.
// RL12: set-reset latch follows data while set; reset clears to zero.
// RL13: counter counts rising clock edges, clears on reset, saturates 65535.
// RL14: arithmetic gives sum, difference, product, quotient of two operands.
// RL15: comparator uses configured relation; true drives output high.
// RL16: hysteresis output sets above max, clears below min, else holds.
// RL17: digital-to-analog gives exactly 0 or 1.
// RL18: 16 digital operands form analog value, BCD or binary.
// RL19: analog value expressed as 16 bits, BCD or binary.
// RL20: pulse train alternates high and low times while enabled.
// RL21: edge detect output active on low-to-high change.
// RL22: validity output one for finite value, zero otherwise.
// RL23: evaluation runs on a 2, 10 or 20 ms cycle.
// RL24: timers add run periods; edges compare with previous run.
`timescale 1ns/1ps
`include "plp_defs.svh"
module plp_engine import plp_pkg::*; #(
	parameter int MS_CYCLES = `PLP_MS_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [15:0] logicOut
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [15:0] lowMask(input logic [4:0] n, input logic [4:0] lo);
		logic [4:0] c;
		c = (n < lo) ? lo : ((n > 5'd16) ? 5'd16 : n);
		lowMask = 16'((17'h1 << c) - 17'h1);
	endfunction : lowMask
	function automatic logic [4:0] periodMs(input logic [1:0] sel);
		case (plp_cycle_e'(sel))
			PLP_CYC_10MS: periodMs = 5'd10;
			PLP_CYC_20MS: periodMs = 5'd20;
			default:      periodMs = 5'd2;
		endcase
	endfunction : periodMs
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rstMeta;
	logic rstN;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end
	// ----------------------------------------
	// software registers
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [31:0] din;
	logic [31:0] anaA;
	logic [31:0] anaB;
	logic [31:0] anaC;
	logic [31:0] tPulse;
	logic [31:0] tDelay;
	logic [31:0] tHigh;
	logic [31:0] tLow;
	logic        wrEn;
	assign wrEn = psel && penable && pready && pwrite;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			ctrl   <= `PLP_CTRL_RST;
			din    <= 32'h0;
			anaA   <= 32'h0;
			anaB   <= 32'h0;
			anaC   <= 32'h0;
			tPulse <= 32'h0;
			tDelay <= 32'h0;
			tHigh  <= 32'h0;
			tLow   <= 32'h0;
		end else if (wrEn) begin
			case (paddr)
				`PLP_OFF_CTRL:  ctrl   <= pwdata;
				`PLP_OFF_DIN:   din    <= pwdata;
				`PLP_OFF_ANA_A: anaA   <= pwdata;
				`PLP_OFF_ANA_B: anaB   <= pwdata;
				`PLP_OFF_ANA_C: anaC   <= pwdata;
				`PLP_OFF_T_PUL: tPulse <= pwdata;
				`PLP_OFF_T_DLY: tDelay <= pwdata;
				`PLP_OFF_T_HI:  tHigh  <= pwdata;
				`PLP_OFF_T_LO:  tLow   <= pwdata;
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// run-cycle tick
	// ----------------------------------------
	logic [31:0] msDiv;
	logic [4:0]  msCount;
	logic        msTick;
	logic        runTick;
	logic [4:0]  stepMs;
	assign stepMs = periodMs(ctrl[`PLP_C_CYC_HI:`PLP_C_CYC_LO]);
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			msDiv  <= 32'h0;
			msTick <= 1'b0;
		end else begin
			msTick <= (msDiv == 32'(MS_CYCLES - 1));
			msDiv  <= (msDiv == 32'(MS_CYCLES - 1)) ? 32'h0 : msDiv + 32'h1;
		end
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			msCount <= 5'h0;
			runTick <= 1'b0;
		end else begin
			runTick <= 1'b0;
			if (!ctrl[`PLP_C_RUN]) msCount <= 5'h0;
			else if (msTick) begin
				if (msCount >= stepMs - 5'h1) begin // see RL23
					msCount <= 5'h0;
					runTick <= 1'b1;
				end else msCount <= msCount + 5'h1;
			end
		end
	end
	// ----------------------------------------
	// digital primitives
	// ----------------------------------------
	logic [15:0] opMask;
	logic [15:0] fanMask;
	logic [14:0] flags;
	logic [10:0] digQ;
	logic [3:0]  tmrQ;
	logic [15:0] fanOut;
	logic        prevClk;
	logic        prevRise;
	logic        cmpTrue;
	logic        valid;
	assign opMask  = lowMask(ctrl[`PLP_C_OPN_HI:`PLP_C_OPN_LO], 5'd2);
	assign fanMask = lowMask(ctrl[`PLP_C_FAN_HI:`PLP_C_FAN_LO], 5'd1);
	assign valid   = (anaA != `PLP_ANA_INVALID);
	assign flags   = {tmrQ, digQ};
	always_comb begin
		case (plp_rel_e'(ctrl[`PLP_C_REL_HI:`PLP_C_REL_LO]))
			PLP_REL_GT: cmpTrue = $signed(anaA) >  $signed(anaB);
			PLP_REL_LT: cmpTrue = $signed(anaA) <  $signed(anaB);
			PLP_REL_EQ: cmpTrue = anaA == anaB;
			PLP_REL_NE: cmpTrue = anaA != anaB;
			PLP_REL_GE: cmpTrue = $signed(anaA) >= $signed(anaB);
			PLP_REL_LE: cmpTrue = $signed(anaA) <= $signed(anaB);
			default:    cmpTrue = 1'b0;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			digQ     <= 11'h0;
			fanOut   <= 16'h0;
			prevClk  <= 1'b0;
			prevRise <= 1'b0;
		end else if (runTick) begin
			digQ[`PLP_F_AND] <= &(din[15:0] | ~opMask); // see RL1
			digQ[`PLP_F_OR]  <= |(din[15:0] & opMask); // see RL2
			digQ[`PLP_F_XOR] <= din[0] ^ din[1]; // see RL3
			digQ[`PLP_F_NOT] <= !din[0]; // see RL4
			fanOut           <= din[0] ? fanMask : 16'h0; // see RL5
			digQ[`PLP_F_MUX] <= din[`PLP_D_SEL] ? din[1] : din[0]; // see RL6
			prevClk          <= din[`PLP_D_CLK];
			if (din[`PLP_D_CLK] && !prevClk)
				digQ[`PLP_F_EDGEQ] <= din[`PLP_D_DATA]; // see RL11
			if (din[`PLP_D_RST]) digQ[`PLP_F_SRQ] <= 1'b0; // see RL12
			else if (din[`PLP_D_SET]) digQ[`PLP_F_SRQ] <= din[`PLP_D_DATA];
			digQ[`PLP_F_CMP] <= cmpTrue; // see RL15
			if ($signed(anaA) > $signed(anaC)) digQ[`PLP_F_HYST] <= 1'b1; // see RL16
			else if ($signed(anaA) < $signed(anaB)) digQ[`PLP_F_HYST] <= 1'b0;
			prevRise            <= din[0];
			digQ[`PLP_F_RISE]  <= din[0] && !prevRise; // see RL21, RL24
			digQ[`PLP_F_VALID] <= valid; // see RL22
		end
	end
	// ----------------------------------------
	// counter
	// ----------------------------------------
	logic [15:0] count;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) count <= 16'h0;
		else if (runTick) begin
			if (din[`PLP_D_RST]) count <= 16'h0; // see RL13
			else if (din[`PLP_D_CLK] && !prevClk && count != `PLP_CNT_MAX)
				count <= count + 16'h1;
		end
	end
	// ----------------------------------------
	// timers
	// ----------------------------------------
	localparam plp_tmode_e TMODES [4] = '{PLP_T_PULSE, PLP_T_ONDLY, PLP_T_OFFDLY, PLP_T_TRAIN};
	logic [31:0] tOn  [4];
	logic [31:0] tOff [4];
	logic [3:0]  tIn;
	assign tOn[0]  = tPulse;
	assign tOn[1]  = tDelay;
	assign tOn[2]  = tDelay;
	assign tOn[3]  = tHigh;
	assign tOff[0] = tLow;
	assign tOff[1] = tLow;
	assign tOff[2] = tLow;
	assign tOff[3] = tLow;
	assign tIn     = {din[`PLP_D_TRAIN], {3{din[`PLP_D_TIN]}}};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tmr
			plp_timer #(.MODE(TMODES[gi])) u_tmr ( // see RL8, RL9, RL10, RL20, RL24
				.clk    (sys_clk),
				.rstN   (rstN),
				.tick   (runTick),
				.stepMs (stepMs),
				.inBit  (tIn[gi]),
				.durOn  (tOn[gi]),
				.durOff (tOff[gi]),
				.q      (tmrQ[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// analog primitives
	// ----------------------------------------
	logic [31:0] sum;
	logic [31:0] diff;
	logic [31:0] prod;
	logic [31:0] quot;
	logic [31:0] amux;
	logic [31:0] d2a;
	logic [31:0] bcd2a;
	logic [31:0] bin2a;
	logic [31:0] a2c;
	logic [31:0] cBcdVal;
	logic [31:0] cBinVal;
	logic [15:0] cBcdBits;
	logic [15:0] cBinBits;
	logic        anyBad;
	logic [63:0] wideProd;
	assign anyBad   = !valid || (anaB == `PLP_ANA_INVALID);
	assign wideProd = $signed(anaA) * $signed(anaB);
	plp_code_conv u_conv (
		.bitsIn  (din[15:0]),
		.valIn   (anaA),
		.bcdVal  (cBcdVal),
		.binVal  (cBinVal),
		.bcdBits (cBcdBits),
		.binBits (cBinBits)
	);
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			sum   <= 32'h0;
			diff  <= 32'h0;
			prod  <= 32'h0;
			quot  <= 32'h0;
			amux  <= 32'h0;
			d2a   <= 32'h0;
			bcd2a <= 32'h0;
			bin2a <= 32'h0;
			a2c   <= 32'h0;
		end else if (runTick) begin
			sum   <= anyBad ? `PLP_ANA_INVALID : anaA + anaB; // see RL14
			diff  <= anyBad ? `PLP_ANA_INVALID : anaA - anaB;
			prod  <= anyBad ? `PLP_ANA_INVALID : wideProd[31:0];
			quot  <= (anyBad || anaB == 32'h0) ? `PLP_ANA_INVALID
				: 32'($signed(anaA) / $signed(anaB));
			amux  <= din[`PLP_D_SEL] ? anaB : anaA; // see RL7
			d2a   <= {31'h0, din[0]}; // see RL17
			bcd2a <= cBcdVal; // see RL18
			bin2a <= cBinVal;
			a2c   <= {cBinBits, cBcdBits}; // see RL19
		end
	end
	// ----------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0;
			logicOut <= 16'h0;
		end else begin
			pready   <= psel && !penable;
			logicOut <= {1'b0, flags};
			if (psel && !penable) begin
				pslverr <= 1'b0;
				case (paddr)
					`PLP_OFF_CTRL:  prdata <= ctrl;
					`PLP_OFF_DIN:   prdata <= din;
					`PLP_OFF_ANA_A: prdata <= anaA;
					`PLP_OFF_ANA_B: prdata <= anaB;
					`PLP_OFF_ANA_C: prdata <= anaC;
					`PLP_OFF_T_PUL: prdata <= tPulse;
					`PLP_OFF_T_DLY: prdata <= tDelay;
					`PLP_OFF_T_HI:  prdata <= tHigh;
					`PLP_OFF_T_LO:  prdata <= tLow;
					`PLP_OFF_FLAGS: prdata <= {17'h0, flags};
					`PLP_OFF_FAN:   prdata <= {16'h0, fanOut};
					`PLP_OFF_COUNT: prdata <= {16'h0, count};
					`PLP_OFF_SUM:   prdata <= sum;
					`PLP_OFF_DIFF:  prdata <= diff;
					`PLP_OFF_PROD:  prdata <= prod;
					`PLP_OFF_QUOT:  prdata <= quot;
					`PLP_OFF_AMUX:  prdata <= amux;
					`PLP_OFF_D2A:   prdata <= d2a;
					`PLP_OFF_BCD2A: prdata <= bcd2a;
					`PLP_OFF_BIN2A: prdata <= bin2a;
					`PLP_OFF_A2C:   prdata <= a2c;
					default: begin
						prdata  <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_and;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && ((din[15:0] & opMask) != opMask) |=> !flags[`PLP_F_AND];
	endproperty
	a_and: assert property (p_and) else $error("and high with operand low"); // see RL1
	property p_or;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && ((din[15:0] & opMask) == 16'h0) |=> !flags[`PLP_F_OR];
	endproperty
	a_or: assert property (p_or) else $error("or high with no operand"); // see RL2
	property p_xor;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && (din[0] == din[1]) |=> !flags[`PLP_F_XOR];
	endproperty
	a_xor: assert property (p_xor) else $error("xor high on equal"); // see RL3
	property p_sr;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && din[`PLP_D_RST] |=> !flags[`PLP_F_SRQ] && count == 16'h0;
	endproperty
	a_sr: assert property (p_sr) else $error("reset operand ignored"); // see RL12
	property p_sat;
		@(posedge sys_clk) disable iff (!rstN)
		count == `PLP_CNT_MAX && !din[`PLP_D_RST] |=> count == `PLP_CNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("counter left saturation"); // see RL13
	property p_hyst;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && $signed(anaA) > $signed(anaC) |=> flags[`PLP_F_HYST];
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis not set"); // see RL16
	property p_valid;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && anaA == `PLP_ANA_INVALID |=> !flags[`PLP_F_VALID] && sum == `PLP_ANA_INVALID;
	endproperty
	a_valid: assert property (p_valid) else $error("invalid value passed"); // see RL22
	property p_tick;
		@(posedge sys_clk) disable iff (!rstN)
		runTick |=> !runTick [*2];
	endproperty
	a_tick: assert property (p_tick) else $error("run ticks too close"); // see RL23
	property p_rise;
		@(posedge sys_clk) disable iff (!rstN)
		runTick && din[0] && !prevRise |=> flags[`PLP_F_RISE] ##1 flags[`PLP_F_RISE];
	endproperty
	a_rise: assert property (p_rise) else $error("edge missed"); // see RL21
	property p_apb;
		@(posedge sys_clk) disable iff (!rstN)
		psel && !penable |=> pready ##1 !pready || (psel && !penable);
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer late"); // see apb slave, zero wait states
endmodule : plp_engine

// [plp_engine_tb.sv]
// Purpose: self-checking bench for the logic primitive engine
// Assumes: MS_CYCLES of 4, zero-wait APB slave
// Notes:   transfers queue their expected answer, a monitor compares
`timescale 1ns/1ps
`include "plp_defs.svh"
module plp_engine_tb import plp_pkg::*;;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	typedef struct {logic [31:0] e; logic [31:0] m; logic r; logic x;} plp_note_s;
	logic        sysClk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] seed = 32'h11;
	logic        pready;
	logic        pslverr;
	logic [15:0] logicOut;
	int          miscompares = 0;
	int          nTests = 0;
	plp_note_s   q[$];
	always #2.5 sysClk = ~sysClk;
	plp_engine #(.MS_CYCLES(4)) DUT (.sys_clk(sysClk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .logicOut(logicOut));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(string n, logic [31:0] e, logic [31:0] g);
		nTests++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	always @(posedge sysClk) begin : mon
		plp_note_s t;
		if (psel && penable && pready === 1'b1) begin
			if (q.size() == 0) begin
				check("spare", 32'h0, 32'h1);
			end else begin
				t = q.pop_front();
				check("pslverr", {31'h0, t.x}, {31'h0, pslverr});
				if (t.r)
					check("prdata", t.e & t.m, prdata & t.m);
			end
		end
	end
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e,
		logic [31:0] m, logic x);
		int n;
		q.push_back('{e, m, !w, x});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sysClk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			miscompares++;
			finish_test();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sysClk);
		end
	endtask : apb
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask : rd
	task automatic idle(int c);
		repeat (c) @(posedge sysClk);
	endtask : idle
	function automatic logic [31:0] rnd();
		for (int k = 0; k < 32; k++)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd
	function automatic logic [31:0] bcd_val(logic [15:0] b);
		int v = 0;
		for (int k = 3; k >= 0; k--) begin
			if (b[4*k+:4] > 4'h9)
				return `PLP_ANA_INVALID;
			v = v * 10 + b[4*k+:4];
		end
		return v;
	endfunction : bcd_val
	function automatic logic [15:0] bcd_bits(int v);
		logic [15:0] r;
		for (int k = 0; k < 4; k++) begin
			r[4*k+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction : bcd_bits
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin : main
		logic signed [31:0] a, b;
		logic [31:0]        din, m, k;
		logic               c;
		int                 p;
		static int          hv[4] = '{25, 15, 5, 15};
		static logic        he[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		idle(4);
		resetn <= 1'b1;
		idle(3);
		rd(`PLP_OFF_CTRL, `PLP_CTRL_RST, 32'hffff_ffff);
		apb(1'b0, 8'hfc, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
		apb(1'b1, 8'hfc, 32'h0, 32'h0, 32'h0, 1'b1);
		for (int i = 0; i < 8; i++) begin
			din = rnd() & 32'h0001_ffff;
			m = rnd();
			a = $signed(m[15:0]);
			b = $signed(m[31:16]) | 1;
			p = (i % 3 == 0) ? 2 : (i % 3 == 1) ? 10 : 20;
			wr(`PLP_OFF_DIN, din);
			wr(`PLP_OFF_ANA_A, a);
			wr(`PLP_OFF_ANA_B, b);
			wr(`PLP_OFF_CTRL, {13'h0, 3'(i), 2'h0, 5'(1 + 2 * i), 5'(2 + 2 * i), 2'h1, 2'(i % 3)});
			idle(8 * p);
			k = (32'h1 << (2 + 2 * i)) - 1;
			case (3'(i))
				PLP_REL_GT: c = a > b;
				PLP_REL_LT: c = a < b;
				PLP_REL_EQ: c = a == b;
				PLP_REL_NE: c = a != b;
				PLP_REL_GE: c = a >= b;
				PLP_REL_LE: c = a <= b;
				default: c = 1'b0;
			endcase
			rd(`PLP_OFF_FLAGS, {21'h0, 1'b1, 2'h0, c, 2'h0, din[16] ? din[1] : din[0], ~din[0],
				din[0] ^ din[1], |(din & k), (din & k) == k}, 32'h49f);
			rd(`PLP_OFF_FAN, din[0] ? (32'h1 << (1 + 2 * i)) - 1 : 32'h0, '1);
			rd(`PLP_OFF_SUM, a + b, '1);
			rd(`PLP_OFF_DIFF, a - b, '1);
			rd(`PLP_OFF_PROD, a * b, '1);
			rd(`PLP_OFF_QUOT, a / b, '1);
			rd(`PLP_OFF_AMUX, din[16] ? b : a, '1);
			rd(`PLP_OFF_D2A, {31'h0, din[0]}, '1);
			rd(`PLP_OFF_BCD2A, bcd_val(din[15:0]), '1);
			rd(`PLP_OFF_BIN2A, {16'h0, din[15:0]}, '1);
			rd(`PLP_OFF_A2C, {a < 0 ? 16'h0 : a[15:0],
				bcd_bits(a < 0 ? 0 : a > 9999 ? 9999 : a)}, '1);
		end
		wr(`PLP_OFF_CTRL, 32'h4);
		wr(`PLP_OFF_ANA_B, 32'd10);
		wr(`PLP_OFF_ANA_C, 32'd20);
		for (int j = 0; j < 4; j++) begin
			wr(`PLP_OFF_ANA_A, hv[j]);
			idle(16);
			rd(`PLP_OFF_FLAGS, {23'h0, he[j], 8'h0}, 32'h100);
		end
		wr(`PLP_OFF_ANA_A, `PLP_ANA_INVALID);
		idle(16);
		rd(`PLP_OFF_FLAGS, 32'h0, 32'h400);
		rd(`PLP_OFF_SUM, `PLP_ANA_INVALID, '1);
		rd(`PLP_OFF_A2C, 32'h0, '1);
		wr(`PLP_OFF_DIN, 32'h10_0000);
		idle(16);
		for (int j = 0; j < 3; j++) begin
			wr(`PLP_OFF_DIN, 32'h6_0000);
			idle(16);
			wr(`PLP_OFF_DIN, 32'h0);
			idle(16);
		end
		rd(`PLP_OFF_COUNT, 32'h3, '1);
		rd(`PLP_OFF_FLAGS, 32'h20, 32'h20);
		wr(`PLP_OFF_DIN, 32'h0c_0000);
		idle(16);
		rd(`PLP_OFF_FLAGS, 32'h40, 32'h40);
		wr(`PLP_OFF_DIN, 32'h1c_0000);
		idle(16);
		rd(`PLP_OFF_FLAGS, 32'h0, 32'h40);
		wr(`PLP_OFF_T_PUL, 32'd6);
		wr(`PLP_OFF_T_DLY, 32'd6);
		wr(`PLP_OFF_T_HI, 32'd100);
		wr(`PLP_OFF_T_LO, 32'd100);
		wr(`PLP_OFF_DIN, 32'h60_0000);
		idle(8);
		rd(`PLP_OFF_FLAGS, 32'h6800, 32'h7800);
		idle(60);
		rd(`PLP_OFF_FLAGS, 32'h7000, 32'h7800);
		check("logicOut", 32'h7000, {16'h0, logicOut} & 32'h7800);
		wr(`PLP_OFF_DIN, 32'h0);
		idle(8);
		rd(`PLP_OFF_FLAGS, 32'h2000, 32'h7800);
		idle(60);
		rd(`PLP_OFF_FLAGS, 32'h0, 32'h7800);
		finish_test();
	end
endmodule : plp_engine_tb
